// file: flash_ctrl_pkg.sv
// constants, states and field layout shared by the flash programming control
// assumes one 25 MHz system clock and a synchronous active-high chip reset
// Notes on behaviour
// R1 - in boot mode, wait about 100 states after reset, then time the serial low period
// R2 - host holds the serial input high when reset is released
// R3 - boot mode erases every block unless the whole array reads all ones
// R4 - software uses no interrupts while programming or erasing
// R5 - at hand-off clear serial enables, keep the baud divisor, drive serial out high
// R6 - at hand-off every other register keeps its value
// R7 - leaving boot mode needs the chip reset held for 20 clocks or more
// R8 - mode pins and write permit stay fixed in boot mode until a chip reset
// R9 - watchdog reset in boot mode keeps state and restarts the boot program
// R10 - write permit stays high while booting, programming or erasing
// R11 - boot select mode 5 or 7 with write permit high enters user program mode
// R12 - in mode 6 nothing is programmed and write permit is held low
// R13 - flash read data is invalid while a program or erase pulse runs
// R14 - software clears control bits 6 to 0 before ordinary flash reads
// R15 - setup, pulse and verify bits select program, erase and the two verify states
// R16 - nothing is programmed or erased while write permit is low
// R17 - software programs only erased locations, never an address twice
// R18 - software changes one control bit per write
// R19 - after dropping to setup, software passes the enable state before re-entering
// R20 - after the enable settle wait, 128 bytes from a 00 or 80 boundary are latched
// R21 - short pages are still sent in full, padded with FF
// R22 - software arms the watchdog, sets setup, waits the setup time, then sets pulse
// R23 - the programming pulse lasts exactly while the pulse bit is set; programPulse follows the bit one clock later, and only after the setup wait
// R24 - the enable and setup settle waits are cycle counts derived from the clock rate; the boot settle is a fixed state count
package flash_ctrl_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // timing
   localparam int CLK_HZ            = 25_000_000;
   localparam int BOOT_READY_STATES = 100;
   localparam int ENABLE_SETTLE_US  = 1;
   localparam int SETUP_SETTLE_US   = 50;
   localparam int ENABLE_SETTLE_CYC = (ENABLE_SETTLE_US * (CLK_HZ / 1_000_000) > 0) ?
                                      ENABLE_SETTLE_US * (CLK_HZ / 1_000_000) : 1;
   localparam int SETUP_SETTLE_CYC  = (SETUP_SETTLE_US * (CLK_HZ / 1_000_000) > 0) ?
                                      SETUP_SETTLE_US * (CLK_HZ / 1_000_000) : 1;
   localparam int WAIT_W            = 16;

   ////////////////////////////////////////////////////////////////////////////
   // flash mode control register layout
   localparam int BIT_PERMIT = 7;
   localparam int BIT_SWE    = 6;
   localparam int BIT_ESU    = 5;
   localparam int BIT_PSU    = 4;
   localparam int BIT_EV     = 3;
   localparam int BIT_PV     = 2;
   localparam int BIT_E      = 1;
   localparam int BIT_P      = 0;
   localparam logic [7:0] CTRL_RESET     = 8'h00;
   localparam logic [7:0] CTRL_SOFT_MASK = 8'h7F;

   ////////////////////////////////////////////////////////////////////////////
   // boot select pin codes (top bit inverted in boot mode)
   localparam logic [2:0] PINS_BOOT5 = 3'h1;
   localparam logic [2:0] PINS_BOOT7 = 3'h3;
   localparam logic [2:0] PINS_USER5 = 3'h5;
   localparam logic [2:0] PINS_USER7 = 3'h7;

   ////////////////////////////////////////////////////////////////////////////
   // page and array geometry
   localparam int PAGE_BYTES = 128;
   localparam int ADDR_W     = 18;
   localparam logic [ADDR_W-1:0] FLASH_LAST_ADDR = 18'h3_FFFF;

   ////////////////////////////////////////////////////////////////////////////
   // serial rate estimate: start bit plus eight zero bits, 32 ticks per bit
   localparam int BAUD_CELLS    = 9;
   localparam int BAUD_TICKS    = 32;
   localparam int LOW_W         = 16;

   typedef enum {
      BOOT_OFF, BOOT_SETTLE, BOOT_WAIT_LOW, BOOT_MEASURE,
      BOOT_BLANK, BOOT_ERASE, BOOT_RUN, BOOT_DONE
   } boot_state_t;

   typedef enum {
      OP_IDLE, OP_ENABLED, OP_PROG_SETUP, OP_PROGRAM,
      OP_ERASE_SETUP, OP_ERASE, OP_PROG_VERIFY, OP_ERASE_VERIFY
   } flash_op_t;

endpackage

// file: page_latch.sv
// page buffer holding one page of program address and data
// assumes writes arrive on the system clock from the control logic
module page_latch #(
   parameter int DEPTH  = 128,
   parameter int ADDR_W = 18
) (
   input  wire logic                      clk,
   input  wire logic                      rst,
   input  wire logic                      clear,
   input  wire logic                      writeStrobe,
   input  wire logic [ADDR_W-1:0]         writeAddr,
   input  wire logic [7:0]                writeData,
   input  wire logic [$clog2(DEPTH)-1:0]  readIndex,
   output logic      [ADDR_W-1:0]         baseAddr,
   output logic      [$clog2(DEPTH):0]    byteCount,
   output logic                           pageComplete,
   output logic                           addrError,
   output logic      [7:0]                readData
);
   localparam int IDX_W = $clog2(DEPTH);

   if (DEPTH < 2 || (1 << IDX_W) != DEPTH || ADDR_W <= IDX_W)
   begin
      $error("page_latch: depth must be a power of two below the address span");
   end

   logic [7:0]        store [DEPTH];
   logic [ADDR_W-1:0] next_baseAddr;
   logic [IDX_W:0]    next_byteCount;
   logic              next_addrError;
   logic              accept;

   // first byte must sit on a page boundary, later ones follow in sequence
   always_comb
   begin
      next_baseAddr  = baseAddr;
      next_byteCount = byteCount;
      next_addrError = addrError;
      accept         = 1'b0;
      if (clear)
      begin
         next_byteCount = '0;
         next_addrError = 1'b0;
      end
      else if (writeStrobe && !pageComplete)
      begin
         if (byteCount == '0)
         begin
            if (writeAddr[IDX_W-1:0] == '0) // R20
            begin
               accept        = 1'b1;
               next_baseAddr = writeAddr;
            end
            else
               next_addrError = 1'b1;
         end
         else if (writeAddr == baseAddr + ADDR_W'(byteCount))
            accept = 1'b1; // R20
         else
            next_addrError = 1'b1;
         if (accept)
            next_byteCount = byteCount + 1'b1;
      end
   end

   // registers plus the byte store
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         baseAddr  <= '0;
         byteCount <= '0;
         addrError <= 1'b0;
         pageComplete <= 1'b0;
         readData  <= 8'h00;
      end
      else
      begin
         baseAddr  <= next_baseAddr;
         byteCount <= next_byteCount;
         addrError <= next_addrError;
         pageComplete <= (next_byteCount == (IDX_W+1)'(DEPTH));
         readData  <= store[readIndex];
      end
      if (accept)
         store[byteCount[IDX_W-1:0]] <= writeData;
   end

endmodule

// file: onchip_flash_program_control.sv
// flash programming control: boot entry, mode selection, control register,
// page latching and gated program / erase pulses
// assumes chip reset held 20 clocks or more and pins steady while in boot mode
module onchip_flash_program_control #(
   parameter int ENABLE_WAIT = flash_ctrl_pkg::ENABLE_SETTLE_CYC,
   parameter int SETUP_WAIT  = flash_ctrl_pkg::SETUP_SETTLE_CYC,
   parameter int BOOT_READY  = flash_ctrl_pkg::BOOT_READY_STATES
) (
   input  wire logic                               clk,
   input  wire logic                               rst,
   input  wire logic                               watchdogReset,
   input  wire logic [2:0]                         boot_select_pins,
   input  wire logic                               flash_write_permit_pin,
   input  wire logic                               serial_in_pin,
   input  wire logic                               ctrlWrite,
   input  wire logic [7:0]                         ctrlWriteData,
   input  wire logic                               flashWrite,
   input  wire logic [flash_ctrl_pkg::ADDR_W-1:0]  flashAddr,
   input  wire logic [7:0]                         flashData,
   input  wire logic [6:0]                         pageReadIndex,
   input  wire logic                               arrayAllOnes,
   input  wire logic                               eraseDone,
   input  wire logic                               bootHandoff,
   output logic      [7:0]                         flash_mode_control_reg,
   output flash_ctrl_pkg::flash_op_t               opState,
   output logic                                    programPulse,
   output logic                                    erasePulse,
   output logic                                    readValid,
   output logic                                    bootMode,
   output logic                                    userProgramMode,
   output logic                                    bootRestart,
   output logic                                    eraseAllBlocks,
   output logic                                    rx_enable_bit,
   output logic                                    tx_enable_bit,
   output logic      [7:0]                         baud_divisor_reg,
   output logic                                    serial_out_pin,
   output logic                                    serialOutEnable,
   output logic      [flash_ctrl_pkg::ADDR_W-1:0]  pageBase,
   output logic                                    pageComplete,
   output logic                                    pageAddrError,
   output logic      [7:0]                         pageReadData
);
   localparam int WW = flash_ctrl_pkg::WAIT_W;
   localparam int LW = flash_ctrl_pkg::LOW_W;

   if (ENABLE_WAIT < 1 || SETUP_WAIT < 1 || BOOT_READY < 1 ||
       ENABLE_WAIT >= (1 << WW) || SETUP_WAIT >= (1 << WW) || BOOT_READY >= (1 << WW))
   begin
      $error("onchip_flash_program_control: wait counts out of range");
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   logic [2:0] modeMeta, modeSync;
   logic       permitMeta, permitSync, rxMeta, rxSync;

   always_ff @(posedge clk)
   begin
      modeMeta   <= boot_select_pins;
      modeSync   <= modeMeta;
      permitMeta <= flash_write_permit_pin;
      permitSync <= permitMeta;
      rxMeta     <= serial_in_pin;
      rxSync     <= rxMeta;
   end

   ////////////////////////////////////////////////////////////////////////////
   // mode capture at reset release
   logic modeCaptured, next_modeCaptured, next_bootMode, next_userProgramMode;

   always_comb
   begin
      next_modeCaptured    = modeCaptured;
      next_bootMode        = bootMode;
      next_userProgramMode = userProgramMode;
      if (watchdogReset && !bootMode)
         next_modeCaptured = 1'b0;
      else if (!modeCaptured)
      begin
         next_modeCaptured = 1'b1;
         next_bootMode = permitSync && (modeSync == flash_ctrl_pkg::PINS_BOOT5 ||
                                        modeSync == flash_ctrl_pkg::PINS_BOOT7);
         next_userProgramMode = permitSync && (modeSync == flash_ctrl_pkg::PINS_USER5 ||
                                               modeSync == flash_ctrl_pkg::PINS_USER7); // R11
      end
      else if (!bootMode)
         next_userProgramMode = permitSync && (modeSync == flash_ctrl_pkg::PINS_USER5 ||
                                               modeSync == flash_ctrl_pkg::PINS_USER7); // R11
   end

   // boot mode is kept across a watchdog reset
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         modeCaptured    <= 1'b0;
         bootMode        <= 1'b0;
         userProgramMode <= 1'b0;
      end
      else
      begin
         modeCaptured    <= next_modeCaptured;
         bootMode        <= next_bootMode; // R9
         userProgramMode <= next_userProgramMode;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // boot sequence: settle, time the low period, blank check, erase, run
   flash_ctrl_pkg::boot_state_t bootState, next_bootState;
   logic [WW-1:0] bootCount, next_bootCount;
   logic [LW-1:0] lowCount, next_lowCount;
   logic [7:0]    next_baud;
   logic          next_rxEn, next_txEn, next_serOut, next_serOe, next_erase, next_restart;

   always_comb
   begin
      next_bootState = bootState;
      next_bootCount = bootCount;
      next_lowCount  = lowCount;
      next_baud      = baud_divisor_reg;
      next_rxEn      = rx_enable_bit;
      next_txEn      = tx_enable_bit;
      next_serOut    = serial_out_pin;
      next_serOe     = serialOutEnable;
      next_erase     = 1'b0;
      next_restart   = 1'b0;
      if (watchdogReset && bootMode)
      begin
         next_bootState = flash_ctrl_pkg::BOOT_SETTLE; // R9
         next_bootCount = '0;
         next_restart   = 1'b1;
      end
      else
      begin
         case (bootState)
            flash_ctrl_pkg::BOOT_OFF:
               if (modeCaptured && bootMode)
                  next_bootState = flash_ctrl_pkg::BOOT_SETTLE;
            flash_ctrl_pkg::BOOT_SETTLE:
               if (bootCount == WW'(BOOT_READY - 1))
                  next_bootState = flash_ctrl_pkg::BOOT_WAIT_LOW; // R1
               else
                  next_bootCount = bootCount + 1'b1;
            flash_ctrl_pkg::BOOT_WAIT_LOW:
               if (!rxSync)
               begin
                  next_bootState = flash_ctrl_pkg::BOOT_MEASURE;
                  next_lowCount  = LW'(1);
               end
            flash_ctrl_pkg::BOOT_MEASURE:
               if (rxSync)
               begin
                  next_bootState = flash_ctrl_pkg::BOOT_BLANK; // R1
                  next_baud = 8'(lowCount / LW'(flash_ctrl_pkg::BAUD_CELLS * flash_ctrl_pkg::BAUD_TICKS));
                  next_rxEn   = 1'b1;
                  next_txEn   = 1'b1;
               end
               else if (lowCount != '1)
                  next_lowCount = lowCount + 1'b1;
            flash_ctrl_pkg::BOOT_BLANK:
               next_bootState = arrayAllOnes ? flash_ctrl_pkg::BOOT_RUN : flash_ctrl_pkg::BOOT_ERASE;
            flash_ctrl_pkg::BOOT_ERASE:
            begin
               next_erase = !eraseDone; // R3
               if (eraseDone)
                  next_bootState = flash_ctrl_pkg::BOOT_RUN;
            end
            flash_ctrl_pkg::BOOT_RUN:
               if (bootHandoff)
               begin
                  next_bootState = flash_ctrl_pkg::BOOT_DONE;
                  next_rxEn   = 1'b0; // R5
                  next_txEn   = 1'b0; // R5
                  next_serOut = 1'b1; // R5
                  next_serOe  = 1'b1; // R5
               end
            flash_ctrl_pkg::BOOT_DONE:
               next_bootState = bootState; // R6
            default:
               next_bootState = flash_ctrl_pkg::BOOT_OFF;
         endcase
      end
   end

   // boot registers; the divisor stays after hand-off
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         bootState        <= flash_ctrl_pkg::BOOT_OFF;
         bootCount        <= '0;
         lowCount         <= '0;
         baud_divisor_reg <= 8'h00;
         rx_enable_bit    <= 1'b0;
         tx_enable_bit    <= 1'b0;
         serial_out_pin   <= 1'b1;
         serialOutEnable  <= 1'b0;
         eraseAllBlocks   <= 1'b0;
         bootRestart      <= 1'b0;
      end
      else
      begin
         bootState        <= next_bootState;
         bootCount        <= next_bootCount;
         lowCount         <= next_lowCount;
         baud_divisor_reg <= next_baud;
         rx_enable_bit    <= next_rxEn;
         tx_enable_bit    <= next_txEn;
         serial_out_pin   <= next_serOut;
         serialOutEnable  <= next_serOe;
         eraseAllBlocks   <= next_erase;
         bootRestart      <= next_restart;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // control register and settle timers
   logic [7:0]    ctrl, next_ctrl;
   logic [WW-1:0] enableCount, next_enableCount, setupCount, next_setupCount;
   logic          enableSettled, setupSettled, programOn, eraseOn, latchWrite;
   flash_ctrl_pkg::flash_op_t next_op;

   assign enableSettled = (enableCount == WW'(ENABLE_WAIT));
   assign setupSettled  = (setupCount == WW'(SETUP_WAIT));
   assign programOn  = ctrl[flash_ctrl_pkg::BIT_P] && ctrl[flash_ctrl_pkg::BIT_PSU] &&
                       ctrl[flash_ctrl_pkg::BIT_SWE] && setupSettled && permitSync; // R16
   assign eraseOn    = ctrl[flash_ctrl_pkg::BIT_E] && ctrl[flash_ctrl_pkg::BIT_ESU] &&
                       ctrl[flash_ctrl_pkg::BIT_SWE] && setupSettled && permitSync; // R16
   assign latchWrite = flashWrite && ctrl[flash_ctrl_pkg::BIT_SWE] && enableSettled &&
                       !ctrl[flash_ctrl_pkg::BIT_PSU] && !ctrl[flash_ctrl_pkg::BIT_ESU] &&
                       flashAddr <= flash_ctrl_pkg::FLASH_LAST_ADDR; // R20

   always_comb
   begin
      next_ctrl = ctrl;
      if (ctrlWrite)
         next_ctrl = ctrlWriteData & flash_ctrl_pkg::CTRL_SOFT_MASK;
      if (!permitSync || (watchdogReset && !bootMode))
         next_ctrl = flash_ctrl_pkg::CTRL_RESET; // R16
      next_enableCount = next_ctrl[flash_ctrl_pkg::BIT_SWE] ?
                         (enableSettled ? enableCount : enableCount + 1'b1) : '0; // R24
      next_setupCount  = (next_ctrl[flash_ctrl_pkg::BIT_PSU] || next_ctrl[flash_ctrl_pkg::BIT_ESU]) ?
                         (setupSettled ? setupCount : setupCount + 1'b1) : '0; // R24
   end

   // operating state decode from the current bits
   always_comb
   begin
      if (!ctrl[flash_ctrl_pkg::BIT_SWE])
         next_op = flash_ctrl_pkg::OP_IDLE;
      else if (ctrl[flash_ctrl_pkg::BIT_PSU])
         next_op = programOn ? flash_ctrl_pkg::OP_PROGRAM : flash_ctrl_pkg::OP_PROG_SETUP; // R15
      else if (ctrl[flash_ctrl_pkg::BIT_ESU])
         next_op = eraseOn ? flash_ctrl_pkg::OP_ERASE : flash_ctrl_pkg::OP_ERASE_SETUP; // R15
      else if (ctrl[flash_ctrl_pkg::BIT_PV])
         next_op = flash_ctrl_pkg::OP_PROG_VERIFY; // R15
      else if (ctrl[flash_ctrl_pkg::BIT_EV])
         next_op = flash_ctrl_pkg::OP_ERASE_VERIFY; // R15
      else
         next_op = flash_ctrl_pkg::OP_ENABLED;
   end

   // control registers and the pulse outputs
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         ctrl                   <= flash_ctrl_pkg::CTRL_RESET;
         enableCount            <= '0;
         setupCount             <= '0;
         flash_mode_control_reg <= flash_ctrl_pkg::CTRL_RESET;
         opState                <= flash_ctrl_pkg::OP_IDLE;
         programPulse           <= 1'b0;
         erasePulse             <= 1'b0;
         readValid              <= 1'b1;
      end
      else
      begin
         ctrl                   <= next_ctrl;
         enableCount            <= next_enableCount;
         setupCount             <= next_setupCount;
         flash_mode_control_reg <= {permitSync, ctrl[6:0]};
         opState                <= next_op;
         programPulse           <= programOn; // R23
         erasePulse             <= eraseOn;
         readValid              <= !(programOn || eraseOn); // R13
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // page buffer; a fresh enable starts a new page
   page_latch #(
      .DEPTH  (flash_ctrl_pkg::PAGE_BYTES),
      .ADDR_W (flash_ctrl_pkg::ADDR_W)
   ) pageBuffer (
      .clk          (clk),
      .rst          (rst),
      .clear        (!ctrl[flash_ctrl_pkg::BIT_SWE]),
      .writeStrobe  (latchWrite),
      .writeAddr    (flashAddr),
      .writeData    (flashData),
      .readIndex    (pageReadIndex),
      .baseAddr     (pageBase),
      .byteCount    (),
      .pageComplete (pageComplete),
      .addrError    (pageAddrError),
      .readData     (pageReadData)
   );

endmodule

// file: flash_host_model.sv
// host side model: sync low stretch on the serial line, erase engine reply
// assumes the bench pulses sendSync once the block is ready to time it
module flash_host_model #(
   parameter int LOW = 964
) (
   input  wire logic clk,
   input  wire logic sendSync,
   input  wire logic eraseAllBlocks,
   output logic      serial_in_pin,
   output logic      eraseDone
);
   timeunit 1ns;
   timeprecision 1ns;
   int eraseWait = 0;
   initial serial_in_pin = 1'b1;
   initial eraseDone = 1'b0;
   // one zero byte seen as a single low stretch, then idle high
   always @(posedge sendSync)
   begin
      serial_in_pin = 1'b0;
      repeat (LOW) @(negedge clk);
      serial_in_pin = 1'b1;
   end
   // erase reply pulse ten cycles into the request
   always @(negedge clk)
   begin
      eraseWait <= eraseAllBlocks ? eraseWait + 1 : 0;
      eraseDone <= (eraseWait == 10);
   end
endmodule

// file: flash_ctrl_chk.sv
// port assertions for the flash programming control
// assumes bind onto the control top, same boot settle count
module flash_ctrl_chk #(
   parameter int BOOT_READY = 100
) (
   input wire logic       clk,
   input wire logic       rst,
   input wire logic [7:0] flash_mode_control_reg,
   input wire logic       programPulse,
   input wire logic       erasePulse,
   input wire logic       readValid,
   input wire logic       bootMode,
   input wire logic       userProgramMode,
   input wire logic       bootRestart,
   input wire logic       eraseAllBlocks,
   input wire logic       arrayAllOnes,
   input wire logic       rx_enable_bit,
   input wire logic       tx_enable_bit,
   input wire logic [7:0] baud_divisor_reg,
   input wire logic       serial_out_pin,
   input wire logic       serialOutEnable
);
   int sinceRst;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////////
   // cycles since reset release, saturating
   always_ff @(posedge clk) sinceRst <= rst ? 0 : sinceRst + int'(sinceRst < 1000);
   ////////////////////////////////////////////////////////////////////////////
   boot_settle_a: assert property ($rose(rx_enable_bit) |-> sinceRst >= BOOT_READY)
      else $error("serial enabled before settle");
   blank_erase_a: assert property (eraseAllBlocks |-> bootMode && !arrayAllOnes)
      else $error("erase of a blank array");
   handoff_pin_a: assert property ($rose(serialOutEnable) |-> serial_out_pin && !rx_enable_bit && !tx_enable_bit)
      else $error("hand-off pin state wrong");
   baud_kept_a: assert property ($fell(rx_enable_bit) |-> $stable(baud_divisor_reg))
      else $error("divisor lost at hand-off");
   restart_keep_a: assert property (bootRestart |-> bootMode && $stable(baud_divisor_reg))
      else $error("restart cleared state");
   user_mode_a: assert property (userProgramMode |-> !bootMode)
      else $error("two modes at once");
   read_block_a: assert property (programPulse || erasePulse |-> !readValid)
      else $error("read valid during pulse");
   permit_gate_a: assert property (!flash_mode_control_reg[7] [*2] |-> !programPulse && !erasePulse)
      else $error("pulse without permit");
   prog_pulse_a: assert property (programPulse |-> flash_mode_control_reg[0] && flash_mode_control_reg[4])
      else $error("program pulse without its bits");
   erase_pulse_a: assert property (erasePulse |-> flash_mode_control_reg[1] && flash_mode_control_reg[5])
      else $error("erase pulse without its bits");
endmodule
bind onchip_flash_program_control flash_ctrl_chk #(.BOOT_READY(BOOT_READY)) flash_ctrl_chk_i (.*);

// file: onchip_flash_program_control_tb.sv
// self-checking bench: boot entry, mode pins, control bits, page latch
// assumes the host model beside the block and the bound checker
module onchip_flash_program_control_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int ENW = 2, SETW = 3, LOWC = 964;
   localparam int BAUD = LOWC / (flash_ctrl_pkg::BAUD_CELLS * flash_ctrl_pkg::BAUD_TICKS);
   logic clk = 0, rst = 1, watchdogReset = 0, flash_write_permit_pin = 1, ctrlWrite = 0, flashWrite = 0;
   logic arrayAllOnes = 0, bootHandoff = 0, sendSync = 0, serial_in_pin, eraseDone;
   logic [2:0] boot_select_pins = flash_ctrl_pkg::PINS_BOOT5;
   logic [7:0] ctrlWriteData = 0, flashData = 0, flash_mode_control_reg, baud_divisor_reg, pageReadData;
   logic [6:0] pageReadIndex = 0;
   logic [17:0] flashAddr = 0, pageBase;
   logic programPulse, erasePulse, readValid, bootMode, userProgramMode, bootRestart, eraseAllBlocks;
   logic rx_enable_bit, tx_enable_bit, serial_out_pin, serialOutEnable, pageComplete, pageAddrError;
   logic [2:0] um [2] = '{flash_ctrl_pkg::PINS_USER5, flash_ctrl_pkg::PINS_USER7};
   flash_ctrl_pkg::flash_op_t opState;
   int miscompares = 0, cmp_count = 0;
   onchip_flash_program_control #(.ENABLE_WAIT(ENW), .SETUP_WAIT(SETW), .BOOT_READY(4))
      onchip_flash_program_control_i (.*);
   flash_host_model #(.LOW(LOWC)) flash_host_model_i (.*);
   ////////////////////////////////////////////////////////////////////////////
   // clock, helpers
   initial forever #20 clk = ~clk;
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic chk(input logic [17:0] seen, exp);
      cmp_count++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("wrong value at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic wt(ref logic s, input logic v);
      for (int k = 0; k < 2000 && s !== v; k++) cyc(1);
      chk(s, v);
   endtask
   task automatic pulse(ref logic s);
      s = 1;
      cyc(1);
      s = 0;
   endtask
   task automatic rstseq(input logic [2:0] pins, input int n);
      rst = 1;
      boot_select_pins = pins;
      cyc(n);
      rst = 0;
      cyc(3);
   endtask
   // control write, then wait until the register shows it
   task automatic wctrl(input logic [7:0] v);
      ctrlWriteData = v;
      pulse(ctrlWrite);
      cyc(2);
   endtask
   function automatic logic [7:0] pat(input int i);
      return (i < 100) ? 8'(i) ^ 8'h3C : 8'hFF;
   endfunction
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial
   begin
      cyc(8000);
      miscompares++;
      stop_test;
   end
   ////////////////////////////////////////////////////////////////////////////
   // scenarios
   initial
   begin
      rstseq(flash_ctrl_pkg::PINS_BOOT5, 12);
      cyc(10);
      pulse(sendSync);
      wt(rx_enable_bit, 1);
      chk(tx_enable_bit, 1);
      chk(baud_divisor_reg, BAUD);
      wt(eraseAllBlocks, 1);
      wt(eraseAllBlocks, 0);
      arrayAllOnes = 1;
      pulse(watchdogReset);
      wt(bootRestart, 1);
      chk(bootMode, 1);
      cyc(10);
      pulse(sendSync);
      cyc(LOWC + 20);
      pulse(bootHandoff);
      cyc(2);
      chk({rx_enable_bit, tx_enable_bit, serial_out_pin, serialOutEnable}, 4'h3);
      chk(baud_divisor_reg, BAUD);
      foreach (um[i])
      begin
         rstseq(um[i], 20);
         chk({userProgramMode, bootMode}, 2'h2);
      end
      wctrl(8'h40);
      chk(flash_mode_control_reg, 8'hC0);
      chk(opState, flash_ctrl_pkg::OP_ENABLED);
      cyc(ENW);
      flashAddr = 18'h0_0081;
      pulse(flashWrite);
      cyc(1);
      chk(pageAddrError, 1);
      wctrl(8'h00);
      wctrl(8'h40);
      cyc(ENW);
      flashWrite = 1;
      for (int i = 0; i < 128; i++)
      begin
         flashAddr = 18'h0_0080 + 18'(i);
         flashData = pat(i);
         cyc(1);
      end
      flashWrite = 0;
      pageReadIndex = 7'h05;
      cyc(2);
      chk({pageComplete, pageAddrError}, 2'h2);
      chk(pageBase, 18'h0_0080);
      chk(pageReadData, pat(5));
      wctrl(8'h50);
      cyc(SETW);
      wctrl(8'h51);
      chk({programPulse, readValid}, 2'h2);
      chk(opState, flash_ctrl_pkg::OP_PROGRAM);
      wctrl(8'h50);
      chk({programPulse, readValid}, 2'h1);
      wctrl(8'h40);
      wctrl(8'h60);
      cyc(SETW);
      wctrl(8'h62);
      chk({erasePulse, readValid}, 2'h2);
      chk(opState, flash_ctrl_pkg::OP_ERASE);
      wctrl(8'h60);
      chk(erasePulse, 0);
      wctrl(8'h40);
      wctrl(8'h44);
      chk(opState, flash_ctrl_pkg::OP_PROG_VERIFY);
      wctrl(8'h40);
      wctrl(8'h48);
      chk(opState, flash_ctrl_pkg::OP_ERASE_VERIFY);
      flash_write_permit_pin = 0;
      cyc(5);
      chk(flash_mode_control_reg, 8'h00);
      wctrl(8'h40);
      chk(flash_mode_control_reg, 8'h00);
      stop_test;
   end
endmodule
